// >>> rtl/prescaled_reload_timer_defs.vh
`ifndef PRESCALED_RELOAD_TIMER_DEFS_VH
`define PRESCALED_RELOAD_TIMER_DEFS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define TMR_ADDR_COUNT 12'h000
`define TMR_ADDR_CONTROL 12'h004
`define TMR_ADDR_PRELOAD 12'h008
`define TMR_ADDR_IRQ_CTRL 12'h00c

// ----------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------
`define TMR_CTL_SRC_BIT 5
`define TMR_CTL_EN_BIT 4
`define TMR_CTL_PSC_MSB 2
`define TMR_CTL_PSC_LSB 0
`define TMR_CTL_WRITE_MASK 8'h37
`define TMR_CTL_RESET 8'h00

// ----------------------------------------------------------------------
// Interrupt control fields and reset values
// ----------------------------------------------------------------------
`define TMR_IRQ_EN_BIT 0
`define TMR_IRQ_FLAG_BIT 1
`define TMR_IRQ_RESET 8'h00
`define TMR_COUNT_RESET 8'h00
`define TMR_PRELOAD_RESET 8'h00
`define TMR_COUNT_MAX 8'hff

`endif

// >>> rtl/clock_edge_sync.v
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Two-stage synchroniser with falling-edge detection of the slow clock.
// ----------------------------------------------------------------------
module clock_edge_sync (
    input wire clk_i,
    input wire reset_i,
    input wire async_i,
    output wire fall_o
);

    reg meta_r;
    reg sync_r;
    reg last_r;

    // Only sync_r and later stages feed the edge detector, never meta_r.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // A high-to-low step of the synchronised level gives one pulse.
    assign fall_o = last_r & ~sync_r;

endmodule

// >>> rtl/tick_prescaler.v
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Power-of-two prescaler producing one-cycle falling-edge ticks.
// ----------------------------------------------------------------------
module tick_prescaler #(
    parameter SEL_W = 3
) (
    input wire clk_i,
    input wire reset_i,
    input wire src_tick_i,
    input wire [SEL_W-1:0] sel_i,
    input wire clear_i,
    output wire tick_o
);

    localparam DIV_W = (1 << SEL_W) - 1;

    reg [DIV_W-1:0] div_r;
    reg [DIV_W:0] ripple;
    integer k;

    // Each stage toggles on its input tick; a falling stage output is the next tick.
    always @* begin
        ripple = {(DIV_W+1){1'b0}};
        ripple[0] = src_tick_i;
        for (k = 0; k < DIV_W; k = k + 1) begin
            ripple[k+1] = ripple[k] & div_r[k];
        end
    end

    // Clearing on a setting change avoids a stray half-period tick.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_r <= {DIV_W{1'b0}};
        end else if (clear_i) begin
            div_r <= {DIV_W{1'b0}};
        end else begin
            div_r <= div_r + {{(DIV_W-1){1'b0}}, src_tick_i};
        end
    end

    assign tick_o = ripple[sel_i];

endmodule

// >>> rtl/prescaled_reload_timer.v
// Contract
// - Source select 0 takes system clock, 1 takes the low-speed clock.
// - Counter advances only while control bit 4 is set; otherwise holds.
// - Prescaler divides the source by two to the prescale code.
// - Each prescaled tick outside a count read, preload write or setting change adds exactly one to the 8-bit count below all-ones.
// - Passing all-ones raises the interrupt request and reloads from preload.
// - With the timer off, a preload write lands in the counter at once.
// - While running, a preload write waits in preload until next overflow.
// - Reading the count register returns the live counter.
// - Counting and reload happen on the falling edge of the tick clock.
// - An overflow raises a wake-up request.
// - Interrupt output is gated by the interrupt enable bit.
// - Control bits 7, 6 and 3 read zero and ignore writes.
// - Any reset leaves the timer off with counting disabled.
// - Counting is inhibited in the cycle a count read or preload write occurs.
`timescale 1ns/1ps
`include "prescaled_reload_timer_defs.vh"

module prescaled_reload_timer #(
    parameter CNT_W = 8,
    parameter PSC_W = 3
) (
    input wire clk_i,
    input wire reset_i,
    input wire low_speed_clock_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output wire pready_o,
    output reg [31:0] prdata_o,
    output wire pslverr_o,
    output wire timer_irq_o,
    output wire wakeup_o
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    reg [7:0] timer_control_r;
    reg [CNT_W-1:0] timer_count_value_r;
    reg [CNT_W-1:0] preload_r;
    reg timer_irq_enable_r;
    reg irq_flag_r;
    reg wake_r;
    reg [PSC_W:0] cfg_last_r;

    wire clk_source_sel = timer_control_r[`TMR_CTL_SRC_BIT];
    wire count_enable_bit = timer_control_r[`TMR_CTL_EN_BIT];
    wire [PSC_W-1:0] prescale_sel = timer_control_r[`TMR_CTL_PSC_MSB:`TMR_CTL_PSC_LSB];

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire access = psel_i & penable_i;
    wire wr_en = access & pwrite_i & pstrb_i[0];
    wire rd_en = access & ~pwrite_i;

    // Returns 1 when the offset names one of the four timer registers.
    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `TMR_ADDR_COUNT) || (a == `TMR_ADDR_CONTROL) ||
                     (a == `TMR_ADDR_PRELOAD) || (a == `TMR_ADDR_IRQ_CTRL);
        end
    endfunction

    wire wr_ctl = wr_en & (paddr_i == `TMR_ADDR_CONTROL);
    wire wr_pre = wr_en & ((paddr_i == `TMR_ADDR_PRELOAD) || (paddr_i == `TMR_ADDR_COUNT));
    wire wr_irq = wr_en & (paddr_i == `TMR_ADDR_IRQ_CTRL);
    wire rd_cnt = rd_en & (paddr_i == `TMR_ADDR_COUNT);

    // Zero wait states keep the bus simple; an unmapped offset flags an error.
    assign pready_o = 1'b1;
    assign pslverr_o = access & ~mapped(paddr_i);

    // ------------------------------------------------------------------
    // Clock source and prescaler
    // ------------------------------------------------------------------
    wire sub_fall;
    wire src_tick;
    wire int_tick;
    wire cfg_change = (cfg_last_r != {clk_source_sel, prescale_sel});

    clock_edge_sync u_sub_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i(low_speed_clock_i),
        .fall_o(sub_fall)
    );

    // The system clock ticks every cycle; the sub clock ticks on its fall.
    assign src_tick = clk_source_sel ? sub_fall : 1'b1;

    tick_prescaler #(
        .SEL_W(PSC_W)
    ) u_psc (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .src_tick_i(src_tick & count_enable_bit),
        .sel_i(prescale_sel),
        .clear_i(cfg_change | ~count_enable_bit),
        .tick_o(int_tick)
    );

    // Remember the configuration so a change is seen one cycle later.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_last_r <= {(PSC_W+1){1'b0}};
        end else begin
            cfg_last_r <= {clk_source_sel, prescale_sel};
        end
    end

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // A count read or preload write blocks the tick, trading a small count error for coherence.
    wire inhibit = rd_cnt | wr_pre;
    wire step = int_tick & count_enable_bit & ~inhibit & ~cfg_change;
    wire overflow = step & (timer_count_value_r == `TMR_COUNT_MAX);

    // Control register with unimplemented bits forced to zero.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_control_r <= `TMR_CTL_RESET;
        end else if (wr_ctl) begin
            timer_control_r <= pwdata_i[7:0] & `TMR_CTL_WRITE_MASK;
        end
    end

    // Preload storage always takes the written value.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            preload_r <= `TMR_PRELOAD_RESET;
        end else if (wr_pre) begin
            preload_r <= pwdata_i[CNT_W-1:0];
        end
    end

    // Live counter: direct load when off, reload on overflow, else step.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_count_value_r <= `TMR_COUNT_RESET;
        end else if (wr_pre && !count_enable_bit) begin
            timer_count_value_r <= pwdata_i[CNT_W-1:0];
        end else if (overflow) begin
            timer_count_value_r <= preload_r;
        end else if (step) begin
            timer_count_value_r <= timer_count_value_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // ------------------------------------------------------------------
    // Interrupt request and wake-up
    // ------------------------------------------------------------------
    // A set arriving with a software clear wins so no overflow is lost.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_flag_r <= 1'b0;
            timer_irq_enable_r <= 1'b0;
        end else begin
            if (overflow) begin
                irq_flag_r <= 1'b1;
            end else if (wr_irq) begin
                irq_flag_r <= pwdata_i[`TMR_IRQ_FLAG_BIT];
            end
            if (wr_irq) begin
                timer_irq_enable_r <= pwdata_i[`TMR_IRQ_EN_BIT];
            end
        end
    end

    // Wake-up pulses on every overflow regardless of the enable.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= overflow;
        end
    end

    assign timer_irq_o = irq_flag_r & timer_irq_enable_r;
    assign wakeup_o = wake_r;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Read data is registered in the setup cycle so it is stable in access.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_o <= 32'h00000000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                `TMR_ADDR_COUNT: begin
                    prdata_o <= {{(32-CNT_W){1'b0}}, timer_count_value_r};
                end
                `TMR_ADDR_CONTROL: begin
                    prdata_o <= {24'h000000, timer_control_r};
                end
                `TMR_ADDR_PRELOAD: begin
                    prdata_o <= {{(32-CNT_W){1'b0}}, preload_r};
                end
                `TMR_ADDR_IRQ_CTRL: begin
                    prdata_o <= {30'h0, irq_flag_r, timer_irq_enable_r};
                end
                default: begin
                    prdata_o <= 32'h00000000;
                end
            endcase
        end
    end

endmodule

// >>> dv/timer_port_asserts.sv
`timescale 1ns/1ps
`include "prescaled_reload_timer_defs.vh"

// ----------------------------------------------------------------------
// Port checker for the reload timer.
// ----------------------------------------------------------------------
module timer_port_checker #(
    parameter CNT_W = 8,
    parameter PSC_W = 3
) (
    input wire clk_i,
    input wire reset_i,
    input wire low_speed_clock_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    input wire pready_o,
    input wire [31:0] prdata_o,
    input wire pslverr_o,
    input wire timer_irq_o,
    input wire wakeup_o
);
    reg en_r;
    reg ie_r;
    reg [7:0] pre_r;
    wire wr = psel_i && penable_i && pwrite_i && pstrb_i[0];
    wire rd_setup = psel_i && !penable_i && !pwrite_i;
    wire mapped = (paddr_i[11:4] == 8'h00) && (paddr_i[1:0] == 2'h0);

    // Shadow enables, so the checks know the mode without looking inside.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            en_r <= 1'b0;
            ie_r <= 1'b0;
            pre_r <= 8'h00;
        end else begin
            if (wr && paddr_i == `TMR_ADDR_CONTROL) en_r <= pwdata_i[4];
            if (wr && paddr_i == `TMR_ADDR_IRQ_CTRL) ie_r <= pwdata_i[0];
            // A reload value of all ones overflows on every tick, so it is tracked.
            if (wr && (paddr_i == `TMR_ADDR_PRELOAD || paddr_i == `TMR_ADDR_COUNT)) begin
                pre_r <= pwdata_i[7:0];
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    AST_CTRL_RESERVED_ZERO: assert property (rd_setup && paddr_i == `TMR_ADDR_CONTROL
        |=> prdata_o[7:6] == 2'h0 && !prdata_o[3]) else $error("reserved bits read set");
    AST_UPPER_BITS_ZERO: assert property (rd_setup |=> prdata_o[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_WAKE_ONE_CYCLE: assert property (wakeup_o && $past(pre_r) != 8'hff |=> !wakeup_o)
        else $error("wake pulse too long");
    AST_READY_ALWAYS: assert property (psel_i |-> pready_o)
        else $error("ready low during a transfer");
    AST_RESET_QUIET: assert property (disable iff (1'b0) reset_i
        |-> !wakeup_o && !timer_irq_o && prdata_o == 32'h0) else $error("busy in reset");
    AST_HOLD_WHEN_OFF: assert property (!en_r && !$past(en_r) && !$past(en_r, 2)
        |-> !wakeup_o) else $error("overflow while off");
    AST_UNMAPPED_ERR: assert property (psel_i && penable_i && !mapped |-> pslverr_o)
        else $error("no error for unmapped");
    AST_MAPPED_OK: assert property (psel_i && penable_i && mapped |-> !pslverr_o)
        else $error("error for mapped");
    AST_PRELOAD_WHEN_OFF: assert property (wr && paddr_i == `TMR_ADDR_PRELOAD && !en_r
        ##2 rd_setup && paddr_i == `TMR_ADDR_COUNT
        |=> prdata_o[7:0] == $past(pwdata_i[7:0], 3)) else $error("preload not in count");
    AST_IRQ_GATED: assert property (timer_irq_o |-> ie_r)
        else $error("irq while masked");
    AST_WAKE_RAISES_IRQ: assert property (wakeup_o && ie_r |-> timer_irq_o)
        else $error("overflow without irq");
endmodule

bind prescaled_reload_timer timer_port_checker #(.CNT_W(CNT_W), .PSC_W(PSC_W))
    i_timer_port_checker (.clk_i(clk_i), .reset_i(reset_i),
    .low_speed_clock_i(low_speed_clock_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .timer_irq_o(timer_irq_o), .wakeup_o(wakeup_o));

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`include "prescaled_reload_timer_defs.vh"

module tb_top;
    logic clk_i = 1'b0;
    logic low_speed_clock_i = 1'b0;
    logic reset_i, psel_i, penable_i, pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [3:0] pstrb_i;
    wire pready_o, pslverr_o, timer_irq_o, wakeup_o;
    wire [31:0] prdata_o;
    logic [31:0] rdat;
    logic rerr;
    int mismatches = 0;
    int comparisons = 0;
    int g;

    // ------------------------------------------------------------------
    // Clocks: the slow clock falls every 8 cycles, away from rising edges.
    // ------------------------------------------------------------------
    always #5 clk_i = ~clk_i;
    always #40 low_speed_clock_i = ~low_speed_clock_i;

    prescaled_reload_timer #(.CNT_W(8), .PSC_W(3)) i_prescaled_reload_timer (
        .clk_i(clk_i), .reset_i(reset_i), .low_speed_clock_i(low_speed_clock_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o),
        .pslverr_o(pslverr_o), .timer_irq_o(timer_irq_o), .wakeup_o(wakeup_o));

    // ------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] e, input logic [31:0] v);
        comparisons++;
        if (v !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, v);
        end
    endtask

    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        rdat = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // Counts edges up to the next wake pulse, so gaps are overflow periods.
    task automatic wake(output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wakeup_o !== 1'b1 && n < 3000);
        if (n >= 3000) mismatches++;
    endtask

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task t_regs;
        apb(0, `TMR_ADDR_CONTROL, 0);
        chk(`TMR_CTL_RESET, rdat);
        apb(1, `TMR_ADDR_CONTROL, 32'hef);
        apb(0, `TMR_ADDR_CONTROL, 0);
        chk(32'h27, rdat);
        apb(0, 12'h010, 0);
        chk(32'h1, {31'h0, rerr});
        apb(1, `TMR_ADDR_PRELOAD, 32'h5a);
        apb(0, `TMR_ADDR_COUNT, 0);
        chk(32'h5a, rdat);
        repeat (20) @(posedge clk_i);
        apb(0, `TMR_ADDR_COUNT, 0);
        chk(32'h5a, rdat);
    endtask

    // Overflow period is four ticks, so it scales with every prescale code.
    task t_psc;
        apb(1, `TMR_ADDR_IRQ_CTRL, 1);
        for (int n = 0; n < 8; n++) begin
            apb(1, `TMR_ADDR_CONTROL, n);
            apb(1, `TMR_ADDR_PRELOAD, 32'hfc);
            apb(1, `TMR_ADDR_CONTROL, 32'h10 | n);
            wake(g);
            wake(g);
            chk(32'h4 << n, g);
        end
        apb(1, `TMR_ADDR_CONTROL, 0);
    endtask

    task t_reload;
        apb(1, `TMR_ADDR_PRELOAD, 32'hfc);
        apb(1, `TMR_ADDR_CONTROL, 32'h10);
        wake(g);
        apb(1, `TMR_ADDR_PRELOAD, 32'hf8);
        wake(g);
        chk(32'h2, g);
        wake(g);
        chk(32'h8, g);
        apb(1, `TMR_ADDR_CONTROL, 32'h20);
        apb(1, `TMR_ADDR_PRELOAD, 32'hfe);
        apb(1, `TMR_ADDR_CONTROL, 32'h30);
        wake(g);
        wake(g);
        chk(32'h10, g);
        apb(1, `TMR_ADDR_CONTROL, 0);
    endtask

    // Flag is set by earlier overflows; mask, set and clear it by hand.
    task automatic t_irq;
        logic [31:0] v [3] = '{32'h2, 32'h3, 32'h1};
        logic [31:0] e [3] = '{32'h0, 32'h1, 32'h0};
        @(negedge clk_i);
        chk(32'h1, {31'h0, timer_irq_o});
        for (int i = 0; i < 3; i++) begin
            apb(1, `TMR_ADDR_IRQ_CTRL, v[i]);
            @(negedge clk_i);
            chk(e[i], {31'h0, timer_irq_o});
        end
    endtask

    task results;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 20000 cycles.
    initial begin
        #200000;
        mismatches++;
        results();
    end

    initial begin
        // A low-to-high step after time zero is seen by every reset process.
        reset_i = 1'b0;
        #1;
        reset_i = 1'b1;
        {psel_i, penable_i, pwrite_i} = 3'h0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        pstrb_i = 4'hf;
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        t_regs();
        t_psc();
        t_reload();
        t_irq();
        results();
    end
endmodule
